// ---- hw/wdt_pkg.sv ----
// Shared constants for the watchdog timer unit: register map, field layout,
// reset values and timebase figures.
// Assumes a 200 MHz system clock and a 32-bit classic Wishbone register bus.
package wdt_pkg;

  // Register byte addresses on the bus
  localparam logic [7:0] WDT_ADR_CTRL = 8'hc0;
  localparam logic [7:0] WDT_ADR_STS = 8'hc4;
  localparam logic [7:0] WDT_ADR_MASK = 8'hc8;
  localparam logic [7:0] WDT_ADR_BIT = 8'hcc;

  // Control byte field positions
  localparam int WDT_PRE_HI = 7;
  localparam int WDT_PRE_LO = 4;
  localparam int WDT_IRQ_SEL_BIT = 3;
  localparam int WDT_FLAG_BIT = 2;
  localparam int WDT_EN_BIT = 1;
  localparam int WDT_UNLOCK_BIT = 0;

  // Single-bit access word: bit index and value
  localparam int WDT_BIT_IDX_HI = 2;
  localparam int WDT_BIT_VAL = 3;

  // Reset values
  localparam logic [7:0] WDT_CTRL_RST = 8'h10;
  localparam logic [3:0] WDT_PRE_RST = 4'h1;

  // Prescale codes
  localparam logic [3:0] WDT_PRE_IMMEDIATE = 4'h8;
  localparam logic [3:0] WDT_PRE_TIMED_MAX = 4'h7;

  // Interrupt status and mask layout
  localparam int WDT_IRQ_W = 1;
  localparam int WDT_IRQ_TIMEOUT = 0;

  // Timebase
  localparam int WDT_CNT_W = 16;
  localparam logic [16:0] WDT_BASE_PERIODS = 17'h00200;
  localparam int WDT_CLK_PERIOD_NS = 5;
  localparam int WDT_CLK_HZ = 1000000000 / WDT_CLK_PERIOD_NS;
  localparam int WDT_TICK_HZ = 32768;

  // Bus data width
  localparam int WDT_DW = 32;

endpackage

// ---- hw/wdt_top.sv ----
// Watchdog timer unit with its classic Wishbone register slave.
// Assumes one clock, an asynchronous power-on reset, and a system that
// resets itself when wd_reset_o pulses; this block survives that pulse.
`timescale 1ns/10ps
module wdt_top #(
  parameter int CLK_HZ = wdt_pkg::WDT_CLK_HZ,
  parameter int TICK_HZ = wdt_pkg::WDT_TICK_HZ
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [wdt_pkg::WDT_DW-1:0] wb_dat_i,
  output logic [wdt_pkg::WDT_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  output logic wd_reset_o
);
  import wdt_pkg::*;

  logic rst_meta_ff;
  logic rst_sync_n;
  logic ack_ff;
  logic [WDT_DW-1:0] rdat_ff;
  logic irq_ff;
  logic wd_reset_ff;
  logic [3:0] pre_ff;
  logic irq_sel_ff;
  logic flag_ff;
  logic en_ff;
  logic unlock_ff;
  logic [WDT_IRQ_W-1:0] sts_ff;
  logic [WDT_IRQ_W-1:0] mask_ff;
  logic [31:0] acc_ff;
  logic tick_ff;
  logic [WDT_CNT_W-1:0] cnt_ff;

  logic [7:0] ctrl_rd;
  logic wr_hit;
  logic ctrl_wr;
  logic bit_wr;
  logic wr_any;
  logic [7:0] wr_val;
  logic accept;
  logic arm;
  logic [16:0] lim_full;
  logic [WDT_CNT_W-1:0] lim;
  logic timeout_evt;
  logic rst_evt;
  logic restart;
  logic [31:0] nxt_acc;
  logic [WDT_IRQ_W-1:0] evt_vec;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_n <= rst_meta_ff;
    end
  end

  // Bus decode; writes land on the edge where the master sees ack
  assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff && wb_sel_i[0];
  assign ctrl_wr = wr_hit && (wb_adr_i == WDT_ADR_CTRL);
  assign bit_wr = wr_hit && (wb_adr_i == WDT_ADR_BIT);
  assign wr_any = ctrl_wr || bit_wr;
  assign ctrl_rd = {pre_ff, irq_sel_ff, flag_ff, en_ff, unlock_ff};

  // Single-bit access rewrites one bit of the current control byte
  always_comb begin
    wr_val = wb_dat_i[7:0];
    if (bit_wr) begin
      wr_val = ctrl_rd;
      wr_val[wb_dat_i[WDT_BIT_IDX_HI:0]] = wb_dat_i[WDT_BIT_VAL];
    end
  end

  // unlock then write
  // A locked write can only arm the unlock, nothing else changes
  assign accept = wr_any && unlock_ff;
  assign arm = wr_any && !unlock_ff && wr_val[WDT_UNLOCK_BIT];

  // prescale decode
  // Timed codes count 512 << code ticks; top terminal count 65535 still fits 16 bits
  assign lim_full = WDT_BASE_PERIODS << pre_ff[2:0];
  assign lim = lim_full[WDT_CNT_W-1:0] - {{(WDT_CNT_W-1){1'b0}}, 1'b1};

  always_comb begin
    timeout_evt = 1'b0;
    if (en_ff) begin
      if (pre_ff == WDT_PRE_IMMEDIATE) begin
        timeout_evt = 1'b1;
      end else if (pre_ff <= WDT_PRE_TIMED_MAX) begin
        timeout_evt = tick_ff && (cnt_ff == lim);
      end
    end
  end

  // code 8 always resets
  // Code 8 ignores the select bit; an interrupt storm would be useless
  assign rst_evt = timeout_evt && (!irq_sel_ff || pre_ff == WDT_PRE_IMMEDIATE);

  assign restart = !en_ff || timeout_evt || (accept && wr_val[WDT_EN_BIT]);

  // Fractional divider; exact 32.768 kHz average with no second clock
  always_comb begin
    nxt_acc = acc_ff + 32'(TICK_HZ);
    if (nxt_acc >= 32'(CLK_HZ)) begin
      nxt_acc = nxt_acc - 32'(CLK_HZ);
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      acc_ff <= 32'h0;
      tick_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      tick_ff <= (acc_ff + 32'(TICK_HZ)) >= 32'(CLK_HZ);
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cnt_ff <= '0;
    end else if (restart) begin
      cnt_ff <= '0;
    end else if (tick_ff) begin
      cnt_ff <= cnt_ff + {{(WDT_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // reset mode reloads control, as the system reset would
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pre_ff <= WDT_CTRL_RST[WDT_PRE_HI:WDT_PRE_LO];
      irq_sel_ff <= WDT_CTRL_RST[WDT_IRQ_SEL_BIT];
      en_ff <= WDT_CTRL_RST[WDT_EN_BIT];
    end else if (rst_evt) begin
      pre_ff <= WDT_PRE_RST;
      irq_sel_ff <= 1'b0;
      en_ff <= 1'b0;
    end else if (accept) begin
      pre_ff <= wr_val[WDT_PRE_HI:WDT_PRE_LO];
      irq_sel_ff <= wr_val[WDT_IRQ_SEL_BIT];
      en_ff <= wr_val[WDT_EN_BIT];
    end
  end

  // sticky timeout flag
  // Power-on reset or an unlocked control write clears it; a timeout beats a clearing write
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      flag_ff <= WDT_CTRL_RST[WDT_FLAG_BIT];
    end else if (timeout_evt) begin
      flag_ff <= 1'b1;
    end else if (accept) begin
      flag_ff <= wr_val[WDT_FLAG_BIT];
    end
  end

  // unlock arms one write
  // Any other bus write in between cancels the unlock
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      unlock_ff <= WDT_CTRL_RST[WDT_UNLOCK_BIT];
    end else if (arm) begin
      unlock_ff <= 1'b1;
    end else if (wr_hit) begin
      unlock_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wd_reset_ff <= 1'b0;
    end else begin
      wd_reset_ff <= rst_evt;
    end
  end

  // Interrupt-mode timeouts feed the sticky status
  always_comb begin
    evt_vec = '0;
    evt_vec[WDT_IRQ_TIMEOUT] = timeout_evt && !rst_evt;
  end

  // Status is write-one-to-clear; a new event wins over the clear
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sts_ff <= '0;
    end else if (wr_hit && wb_adr_i == WDT_ADR_STS) begin
      sts_ff <= (sts_ff & ~wb_dat_i[WDT_IRQ_W-1:0]) | evt_vec;
    end else begin
      sts_ff <= sts_ff | evt_vec;
    end
  end

  // Mask register
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mask_ff <= '0;
    end else if (wr_hit && wb_adr_i == WDT_ADR_MASK) begin
      mask_ff <= wb_dat_i[WDT_IRQ_W-1:0];
    end
  end

  // Level interrupt, registered so it comes straight from a flop
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(sts_ff & mask_ff);
    end
  end

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
    end
  end

  // Read data latched with the ack; unmapped addresses read zero
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rdat_ff <= '0;
    end else if (wb_cyc_i && wb_stb_i && !ack_ff) begin
      case (wb_adr_i)
        WDT_ADR_CTRL: rdat_ff <= {24'h0, ctrl_rd};
        WDT_ADR_STS: rdat_ff <= {{(WDT_DW-WDT_IRQ_W){1'b0}}, sts_ff};
        WDT_ADR_MASK: rdat_ff <= {{(WDT_DW-WDT_IRQ_W){1'b0}}, mask_ff};
        default: rdat_ff <= '0;
      endcase
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign irq_o = irq_ff;
  assign wd_reset_o = wd_reset_ff;

  // Bus handshake shape
  sequence bus_req_s;
    wb_cyc_i && wb_stb_i && !ack_ff;
  endsequence

  sequence bus_ack_s;
    ack_ff ##1 !ack_ff;
  endsequence

  bus_ack_shape_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    bus_req_s |=> bus_ack_s)
    else $error("ack did not follow request by one cycle");

  disabled_quiet_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !en_ff |=> !wd_reset_o && !$rose(sts_ff[WDT_IRQ_TIMEOUT]))
    else $error("watchdog acted while disabled");

  timeout_fire_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    en_ff && pre_ff <= WDT_PRE_TIMED_MAX && tick_ff && cnt_ff == lim
    |=> (wd_reset_o || sts_ff[WDT_IRQ_TIMEOUT]) && flag_ff && cnt_ff == 16'h0000)
    else $error("no timeout at terminal count");

  cnt_step_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    tick_ff && !restart |=> cnt_ff == $past(cnt_ff) + 16'h0001)
    else $error("counter did not advance on tick");

  immediate_reset_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    en_ff && pre_ff == WDT_PRE_IMMEDIATE |=> wd_reset_o)
    else $error("code 8 did not reset at once");

  sequence irq_mode_s;
    sts_ff[WDT_IRQ_TIMEOUT] && !wd_reset_o;
  endsequence

  irq_mode_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    timeout_evt && irq_sel_ff && pre_ff != WDT_PRE_IMMEDIATE |=> irq_mode_s)
    else $error("interrupt mode misbehaved");

  reset_mode_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    timeout_evt && !irq_sel_ff |=> wd_reset_o && !en_ff && pre_ff == WDT_PRE_RST)
    else $error("reset mode misbehaved");

  flag_keep_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    timeout_evt |=> flag_ff ##1 (flag_ff || $past(accept)))
    else $error("timeout flag lost");

  locked_write_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    wr_any && !unlock_ff && !timeout_evt |=> $stable(pre_ff) && $stable(en_ff))
    else $error("control changed without unlock");

  refresh_clear_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    accept && wr_val[WDT_EN_BIT] |=> cnt_ff == 16'h0000)
    else $error("refresh did not restart counter");

  bit_access_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    bit_wr && unlock_ff && !timeout_evt && wb_dat_i[WDT_BIT_IDX_HI:0] == 3'h1
    |=> en_ff == $past(wb_dat_i[WDT_BIT_VAL]))
    else $error("single-bit write lost");

  // Interrupt output follows masked status
  irq_level_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    |(sts_ff & mask_ff) |=> irq_o)
    else $error("irq not raised for unmasked status");

endmodule

// ---- test/wdt_tb_top.sv ----
// Self-checking bench for the watchdog timer unit, with random refresh times
// among hand-written corner cases.
// Assumes wdt_pkg and wdt_top are compiled first; one 200 MHz clock.
`timescale 1ns/10ps
module watchdog_timer_unit_tb_top;
  import wdt_pkg::*;
  localparam int CLK_HZ = 200000000;
  // Fast tick so that a timeout takes thousands, not millions, of cycles
  localparam int TICK_HZ = 20000000;
  localparam int TMO = 512 * (CLK_HZ / TICK_HZ);
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [WDT_DW-1:0] dat = '0;
  logic [WDT_DW-1:0] rdat;
  logic ack;
  logic irq;
  logic wdrst;
  logic [WDT_DW-1:0] q;
  int bad_count = 0;
  int comparisons = 0;
  int rst_pulses = 0;
  int n;
  int r;

  wdt_top #(.CLK_HZ(CLK_HZ), .TICK_HZ(TICK_HZ)) dut_u (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq_o(irq), .wd_reset_o(wdrst)
  );

  // Free-running clock, 5 ns period
  initial begin
    forever #2.5 clk = ~clk;
  end

  // Count system reset requests, sampled once per edge
  always @(posedge clk) begin
    if (wdrst === 1'b1) begin
      rst_pulses++;
    end
  end

  // Expected control byte from its fields; unlock expected as 0, since no read falls while an unlock is armed
  function automatic logic [31:0] ctrl(input logic [3:0] pre, input logic s, input logic f,
                                       input logic e);
    return {24'h0, pre, s, f, e, 1'b0};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // One classic cycle; request held until ack is seen at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = rdat;
    if (k >= 20) begin
      bad_count++;
      $display("wrong value at %0t: no bus answer", $time);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
    xfer(1'b0, a, 32'h0);
    chk(q, exp, msg);
  endtask

  // unlock and control write back to back, nothing between
  task automatic unlock_wr(input logic [31:0] d);
    wr(WDT_ADR_CTRL, 32'h1);
    wr(WDT_ADR_CTRL, d);
  endtask

  // Cycles until reset request or interrupt shows, at most lim
  task automatic wait_evt(input int lim);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (irq !== 1'b1 && wdrst !== 1'b1 && n < lim);
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Hang guard: tests need under 50k cycles, allow 200k
  initial begin
    #1000000;
    bad_count++;
    complete_run;
  end

  initial begin
    void'($urandom(32'hf1acd81b));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(WDT_ADR_CTRL, {24'h0, WDT_CTRL_RST}, "power-up control");
    rd(WDT_ADR_MASK, 32'h0, "mask reset");
    wr(WDT_ADR_CTRL, ctrl(4'h0, 1'b1, 1'b0, 1'b1));
    rd(WDT_ADR_CTRL, {24'h0, WDT_CTRL_RST}, "locked write");
    r = $urandom;
    wr(8'hd0, r);
    rd(8'hd0, 32'h0, "unmapped read");
    // Interrupt mode, shortest period, refreshed at random points
    wr(WDT_ADR_MASK, 32'h1);
    unlock_wr(ctrl(4'h0, 1'b1, 1'b0, 1'b1));
    rd(WDT_ADR_CTRL, ctrl(4'h0, 1'b1, 1'b0, 1'b1), "enabled control");
    repeat (3) begin
      r = 1000 + $urandom_range(3000);
      wait_evt(r);
      chk(n == r, 1, "early timeout");
      unlock_wr(ctrl(4'h0, 1'b1, 1'b0, 1'b1));
    end
    wait_evt(TMO + 100);
    chk(n >= TMO - 20 && n <= TMO + 20, 1, "timeout interval");
    chk(irq, 1'b1, "interrupt raised");
    chk(rst_pulses, 0, "reset in interrupt mode");
    rd(WDT_ADR_STS, 32'h1, "status set");
    rd(WDT_ADR_CTRL, ctrl(4'h0, 1'b1, 1'b1, 1'b1), "flag set");
    wr(WDT_ADR_STS, 32'h1);
    rd(WDT_ADR_STS, 32'h0, "status cleared");
    chk(irq, 1'b0, "interrupt cleared");
    // Masked timeout keeps the line low until the mask opens
    wr(WDT_ADR_MASK, 32'h0);
    wait_evt(TMO + 100);
    chk(n, TMO + 100, "masked interrupt");
    rd(WDT_ADR_STS, 32'h1, "masked status");
    wr(WDT_ADR_MASK, 32'h1);
    wait_evt(4);
    chk(irq, 1'b1, "unmasked interrupt");
    unlock_wr(ctrl(4'h0, 1'b1, 1'b1, 1'b0));
    wr(WDT_ADR_STS, 32'h1);
    // Registered irq needs two edges to fall after the clear
    repeat (2) @(posedge clk);
    chk(irq, 1'b0, "interrupt dropped");
    wait_evt(3 * TMO);
    chk(n, 3 * TMO, "disabled watchdog");
    r = 9 + $urandom_range(6);
    unlock_wr(ctrl(r[3:0], 1'b1, 1'b1, 1'b1));
    wait_evt(TMO + 100);
    chk(n, TMO + 100, "reserved prescale");
    // Reset mode: one pulse, control reloaded, flag kept
    unlock_wr(ctrl(4'h0, 1'b0, 1'b0, 1'b1));
    wait_evt(TMO + 100);
    chk(n >= TMO - 20 && n <= TMO + 20, 1, "reset timeout");
    repeat (2) @(posedge clk);
    chk(rst_pulses, 1, "reset pulse");
    rd(WDT_ADR_CTRL, ctrl(4'h1, 1'b0, 1'b1, 1'b0), "flag after reset");
    unlock_wr(ctrl(4'h8, 1'b0, 1'b0, 1'b1));
    wait_evt(8);
    chk(n <= 4 && wdrst === 1'b1, 1, "immediate reset");
    repeat (2) @(posedge clk);
    chk(rst_pulses, 2, "immediate pulse count");
    rd(WDT_ADR_CTRL, ctrl(4'h1, 1'b0, 1'b1, 1'b0), "after immediate");
    // Code 8 resets even with the interrupt selected
    unlock_wr(ctrl(4'h8, 1'b1, 1'b0, 1'b1));
    wait_evt(8);
    chk(wdrst, 1'b1, "immediate reset, irq selected");
    repeat (2) @(posedge clk);
    chk(rst_pulses, 3, "one pulse, irq selected");
    rd(WDT_ADR_STS, 32'h0, "no status on immediate");
    rd(WDT_ADR_CTRL, ctrl(4'h1, 1'b0, 1'b1, 1'b0), "reload, irq selected");
    // Another write between unlock and control write cancels the unlock
    wr(WDT_ADR_CTRL, 32'h1);
    wr(WDT_ADR_MASK, 32'h1);
    wr(WDT_ADR_CTRL, ctrl(4'h0, 1'b1, 1'b0, 1'b1));
    rd(WDT_ADR_CTRL, ctrl(4'h1, 1'b0, 1'b1, 1'b0), "cancelled unlock");
    // Single-bit access: unlock bit, then enable bit
    wr(WDT_ADR_BIT, 32'h8);
    wr(WDT_ADR_BIT, 32'h9);
    rd(WDT_ADR_CTRL, ctrl(4'h1, 1'b0, 1'b1, 1'b1), "bit enable");
    wr(WDT_ADR_BIT, 32'h8);
    wr(WDT_ADR_BIT, 32'h1);
    rd(WDT_ADR_CTRL, ctrl(4'h1, 1'b0, 1'b1, 1'b0), "bit disable");
    rd(WDT_ADR_BIT, 32'h0, "bit word read");
    complete_run;
  end
endmodule
